/* File: hdl/rrp_pkg.sv */
// Constants, status words and state encoding for the read-record engine
package rrp_pkg;

  // ==========================================
  // Addressing modes on cmd_mode_i
  localparam logic [1:0] MODE_CURRENT = 2'h0;
  localparam logic [1:0] MODE_ABSOLUTE = 2'h1;
  localparam logic [1:0] MODE_NEXT = 2'h2;
  localparam logic [1:0] MODE_PREVIOUS = 2'h3;

  // ==========================================
  // Status word pairs
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  localparam logic [7:0] SW1_SECURITY = 8'h69;
  localparam logic [7:0] SW2_SECURITY = 8'h82;
  localparam logic [7:0] SW1_STRUCTURE = 8'h69;
  localparam logic [7:0] SW2_STRUCTURE = 8'h81;
  localparam logic [7:0] SW1_NOT_FOUND = 8'h6A;
  localparam logic [7:0] SW2_REC_NOT_FOUND = 8'h83;
  localparam logic [7:0] SW2_FILE_NOT_FOUND = 8'h82;
  localparam logic [7:0] SW1_WRONG_LEN = 8'h67;
  localparam logic [7:0] SW2_WRONG_LEN = 8'h00;

  // ==========================================
  // Record numbering starts at one
  localparam int REC_FIRST = 1;

  // ==========================================
  // Sequencer states, Gray along the usual path from ST_IDLE to ST_STATUS
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EVAL = 3'h1,
    ST_FETCH = 3'h3,
    ST_DRAIN = 3'h2,
    ST_STATUS = 3'h6
  } rrp_state_type;

endpackage : rrp_pkg

/* File: hdl/rrp_read_record_engine.sv */
// Read-record command engine with per-file record pointers and response FIFO
`timescale 1ns/1ps

// ==========================================
// Response byte FIFO
module rrp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic empty_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [AW-1:0] last_idx = AW'(DEPTH - 1);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("rrp_fifo: DEPTH must be at least 2");
    end
  endgenerate

  // in_ready_o and out_valid_o drop while ce_i is low so no byte is taken during a freeze
  assign in_ready_o = ce_i && (count_reg != DEPTH_CNT);
  assign out_valid_o = ce_i && (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign empty_o = (count_reg == '0);

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == last_idx) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == last_idx) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : rrp_fifo

// ==========================================
// Top level
// Operation
// - Return one whole record, only from linear fixed or cyclic files.
// - Record chosen by mode and pointer becomes the response data.
// - Read access not satisfied: no data, status 69 82.
// - Successful read ends with status 90 00.
// - Current mode returns pointed record, pointer untouched.
// - Absolute mode returns the numbered record, pointer untouched.
// - Absolute number past last record fails with 6A 83.
// - Next mode advances pointer by one, then returns that record.
// - Next mode without a pointer returns record one and sets pointer.
// - Next at last record of linear file: pointer kept, no data.
// - Next at last record of cyclic file wraps to record one.
// - Previous mode steps pointer back by one, then returns that record.
// - Previous without a pointer returns last record and sets pointer.
// - Previous at record one of linear file: pointer kept, no data.
// - Previous at record one of cyclic file wraps to last record.
// - A failed command leaves the record pointer as it was, except that a valid short file identifier still clears it.
// - Valid short file identifier makes file current and clears its pointer.
// - Selecting a record file anew leaves it without a pointer.
module rrp_read_record_engine #(
  parameter int NUM_FILES = 4,
  parameter int REC_W = 8,
  parameter int LEN_W = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sel_valid_i,
  input wire logic [$clog2(NUM_FILES)-1:0] sel_file_i,
  output logic sel_ready_o,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_mode_i,
  input wire logic [REC_W-1:0] cmd_rec_num_i,
  input wire logic [LEN_W-1:0] cmd_len_i,
  input wire logic cmd_sfi_valid_i,
  input wire logic [4:0] cmd_short_file_identifier_i,
  input wire logic [NUM_FILES-1:0] file_is_record_i,
  input wire logic [NUM_FILES-1:0] file_cyclic_i,
  input wire logic [NUM_FILES-1:0] read_access_ok_i,
  input wire logic [NUM_FILES*REC_W-1:0] file_num_rec_i,
  input wire logic [NUM_FILES*LEN_W-1:0] file_rec_len_i,
  output logic mem_rd_o,
  output logic [$clog2(NUM_FILES)-1:0] mem_file_o,
  output logic [REC_W-1:0] mem_rec_o,
  output logic [LEN_W-1:0] mem_byte_o,
  input wire logic [7:0] mem_rdata_i,
  output logic resp_valid_o,
  input wire logic resp_ready_i,
  output logic [7:0] resp_data_o,
  output logic sw_valid_o,
  output logic [7:0] sw1_o,
  output logic [7:0] sw2_o,
  output logic [$clog2(NUM_FILES)-1:0] cur_file_o
);
  localparam int FW = $clog2(NUM_FILES);
  localparam logic [REC_W-1:0] REC_ONE = REC_W'(rrp_pkg::REC_FIRST);

  generate
    if (NUM_FILES < 2 || NUM_FILES > 32 || REC_W < 1 || LEN_W < 1) begin : g_chk
      $error("rrp_read_record_engine: unsupported parameters");
    end
  endgenerate

  // ==========================================
  // State
  rrp_pkg::rrp_state_type state_reg;
  logic [REC_W-1:0] ptr_reg [NUM_FILES];
  logic [NUM_FILES-1:0] ptr_set_reg;
  logic [FW-1:0] cur_file_reg;
  logic [1:0] mode_reg;
  logic [REC_W-1:0] rec_num_reg;
  logic [LEN_W-1:0] len_reg;
  logic sfi_reg;
  logic [4:0] sfi_id_reg;
  logic [REC_W-1:0] tgt_reg;
  logic [LEN_W-1:0] cnt_reg;
  logic mem_rd_reg;
  logic rd_pend_reg;
  logic [REC_W-1:0] mem_rec_reg;
  logic [LEN_W-1:0] mem_byte_reg;
  logic [7:0] sw1_reg;
  logic [7:0] sw2_reg;
  logic data_seen_reg;
  logic [REC_W-1:0] num_rec_arr [NUM_FILES];
  logic [LEN_W-1:0] rec_len_arr [NUM_FILES];

  for (genvar g = 0; g < NUM_FILES; g++) begin : g_unpack
    assign num_rec_arr[g] = file_num_rec_i[g*REC_W +: REC_W];
    assign rec_len_arr[g] = file_rec_len_i[g*LEN_W +: LEN_W];
  end

  // ==========================================
  // Command decode, evaluated in ST_EVAL from the latched command
  wire cmd_fire = cmd_valid_i && cmd_ready_o && ce_i;
  wire sel_fire = sel_valid_i && sel_ready_o && ce_i;
  wire sfi_ok = sfi_reg && (sfi_id_reg < 5'(NUM_FILES));
  wire [FW-1:0] file = sfi_ok ? FW'(sfi_id_reg) : cur_file_reg;
  wire [REC_W-1:0] nrec = num_rec_arr[file];
  wire [LEN_W-1:0] rlen = rec_len_arr[file];
  wire [REC_W-1:0] ptr = ptr_reg[file];
  wire cyc = file_cyclic_i[file];
  // A short file identifier drops the old pointer for this command
  wire ptr_set = ptr_set_reg[file] && !sfi_ok;
  wire at_last = ptr_set && (ptr == nrec);
  wire at_first = ptr_set && (ptr == REC_ONE);
  wire is_move = mode_reg[1];
  wire [REC_W-1:0] next_tgt = !ptr_set ? REC_ONE :
    (at_last ? REC_ONE : ptr + 1'b1);
  wire [REC_W-1:0] prev_tgt = !ptr_set ? nrec :
    (at_first ? nrec : ptr - 1'b1);
  wire [REC_W-1:0] tgt =
    (mode_reg == rrp_pkg::MODE_CURRENT) ? ptr :
    (mode_reg == rrp_pkg::MODE_ABSOLUTE) ? rec_num_reg :
    (mode_reg == rrp_pkg::MODE_NEXT) ? next_tgt : prev_tgt;
  wire bad_sfi = sfi_reg && !sfi_ok;
  wire bad_struct = !file_is_record_i[file];
  wire denied = !read_access_ok_i[file];
  wire bad_len = (len_reg != '0) && (len_reg != rlen);
  wire not_found =
    ((mode_reg == rrp_pkg::MODE_CURRENT) && !ptr_set) ||
    ((mode_reg == rrp_pkg::MODE_ABSOLUTE) &&
     ((rec_num_reg == '0) || (rec_num_reg > nrec))) ||
    ((mode_reg == rrp_pkg::MODE_NEXT) && at_last && !cyc) ||
    ((mode_reg == rrp_pkg::MODE_PREVIOUS) && at_first && !cyc);
  wire fail = bad_sfi || bad_struct || denied || bad_len || not_found;
  // Priority: unknown file, structure, access, length, then record addressing
  wire [7:0] fail_sw1 = bad_sfi ? rrp_pkg::SW1_NOT_FOUND :
    bad_struct ? rrp_pkg::SW1_STRUCTURE :
    denied ? rrp_pkg::SW1_SECURITY :
    bad_len ? rrp_pkg::SW1_WRONG_LEN : rrp_pkg::SW1_NOT_FOUND;
  wire [7:0] fail_sw2 = bad_sfi ? rrp_pkg::SW2_FILE_NOT_FOUND :
    bad_struct ? rrp_pkg::SW2_STRUCTURE :
    denied ? rrp_pkg::SW2_SECURITY :
    bad_len ? rrp_pkg::SW2_WRONG_LEN : rrp_pkg::SW2_REC_NOT_FOUND;

  // ==========================================
  // Fetch: one read in flight at a time keeps a FIFO slot for its byte
  logic fifo_in_ready;
  logic fifo_empty;
  wire issue = (state_reg == rrp_pkg::ST_FETCH) && !mem_rd_reg && !rd_pend_reg &&
    fifo_in_ready && (cnt_reg != rlen);
  wire fetch_done = (cnt_reg == rlen) && !mem_rd_reg && !rd_pend_reg;

  rrp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(rd_pend_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mem_rdata_i),
    .out_valid_o(resp_valid_o),
    .out_ready_i(resp_ready_i),
    .out_data_o(resp_data_o),
    .empty_o(fifo_empty)
  );

  assign cmd_ready_o = (state_reg == rrp_pkg::ST_IDLE) && !sel_valid_i;
  assign sel_ready_o = (state_reg == rrp_pkg::ST_IDLE);
  assign sw_valid_o = (state_reg == rrp_pkg::ST_STATUS);
  assign sw1_o = sw1_reg;
  assign sw2_o = sw2_reg;
  assign mem_rd_o = mem_rd_reg;
  assign mem_file_o = cur_file_reg;
  assign mem_rec_o = mem_rec_reg;
  assign mem_byte_o = mem_byte_reg;
  assign cur_file_o = cur_file_reg;

  // ==========================================
  // Sequencer
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= rrp_pkg::ST_IDLE;
    end else if (ce_i) begin
      case (state_reg)
        rrp_pkg::ST_IDLE: state_reg <= cmd_fire ? rrp_pkg::ST_EVAL : rrp_pkg::ST_IDLE;
        rrp_pkg::ST_EVAL: state_reg <= fail ? rrp_pkg::ST_STATUS : rrp_pkg::ST_FETCH;
        rrp_pkg::ST_FETCH: state_reg <= fetch_done ? rrp_pkg::ST_DRAIN : rrp_pkg::ST_FETCH;
        rrp_pkg::ST_DRAIN: state_reg <= fifo_empty ? rrp_pkg::ST_STATUS : rrp_pkg::ST_DRAIN;
        rrp_pkg::ST_STATUS: state_reg <= rrp_pkg::ST_IDLE;
        default: state_reg <= rrp_pkg::ST_IDLE;
      endcase
    end
  end

  // Command latch and status word
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= rrp_pkg::MODE_CURRENT;
      rec_num_reg <= '0;
      len_reg <= '0;
      sfi_reg <= 1'b0;
      sfi_id_reg <= '0;
      tgt_reg <= '0;
      sw1_reg <= '0;
      sw2_reg <= '0;
    end else if (ce_i) begin
      if (cmd_fire) begin
        mode_reg <= cmd_mode_i;
        rec_num_reg <= cmd_rec_num_i;
        len_reg <= cmd_len_i;
        sfi_reg <= cmd_sfi_valid_i;
        sfi_id_reg <= cmd_short_file_identifier_i;
      end
      if (state_reg == rrp_pkg::ST_EVAL) begin
        tgt_reg <= tgt;
        sw1_reg <= fail ? fail_sw1 : rrp_pkg::SW1_OK;
        sw2_reg <= fail ? fail_sw2 : rrp_pkg::SW2_OK;
      end
    end
  end

  // Per-file pointers; a failed command never moves them, but a valid short file identifier still clears ptr_set_reg
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_set_reg <= '0;
      cur_file_reg <= '0;
      for (int i = 0; i < NUM_FILES; i++) begin
        ptr_reg[i] <= '0;
      end
    end else if (ce_i) begin
      if (sel_fire) begin
        cur_file_reg <= sel_file_i;
        ptr_set_reg[sel_file_i] <= 1'b0;
      end
      if (state_reg == rrp_pkg::ST_EVAL) begin
        if (sfi_ok) begin
          cur_file_reg <= file;
          ptr_set_reg[file] <= 1'b0;
        end
        if (!fail && is_move) begin
          ptr_reg[file] <= tgt;
          ptr_set_reg[file] <= 1'b1;
        end
      end
    end
  end

  // Byte reader: exactly rlen bytes of the chosen record
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      mem_rd_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      mem_rec_reg <= '0;
      mem_byte_reg <= '0;
      data_seen_reg <= 1'b0;
    end else if (ce_i) begin
      mem_rd_reg <= issue;
      rd_pend_reg <= mem_rd_reg;
      if (state_reg == rrp_pkg::ST_EVAL) begin
        cnt_reg <= '0;
        mem_rec_reg <= tgt;
        data_seen_reg <= 1'b0;
      end else if (issue) begin
        mem_byte_reg <= cnt_reg;
        cnt_reg <= cnt_reg + 1'b1;
      end
      if (rd_pend_reg) begin
        data_seen_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  wire ev = (state_reg == rrp_pkg::ST_EVAL) && ce_i;

  AST_DENIED_STATUS: assert property (
    ev && !bad_sfi && !bad_struct && denied |=>
      sw1_reg == 8'h69 && sw2_reg == 8'h82 && state_reg == rrp_pkg::ST_STATUS)
    else $error("denied read did not answer 69 82 at once");
  AST_OK_STATUS: assert property (
    sw_valid_o && data_seen_reg |-> sw1_o == 8'h90 && sw2_o == 8'h00)
    else $error("read with data did not end with 90 00");
  AST_CURRENT_KEEP: assert property (
    ev && mode_reg == rrp_pkg::MODE_CURRENT |=> ptr_reg[$past(file)] == $past(ptr))
    else $error("current mode moved the pointer");
  AST_ABS_ADDRESS: assert property (
    ev && !fail && mode_reg == rrp_pkg::MODE_ABSOLUTE |=>
      mem_rec_reg == $past(rec_num_reg) && ptr_reg[$past(file)] == $past(ptr))
    else $error("absolute mode addressed wrong record or moved pointer");
  AST_ABS_BEYOND: assert property (
    ev && !bad_sfi && !bad_struct && !denied && !bad_len &&
      mode_reg == rrp_pkg::MODE_ABSOLUTE && rec_num_reg == nrec + 1'b1 |=>
      sw1_reg == 8'h6A && sw2_reg == 8'h83)
    else $error("record past last did not fail with 6A 83");
  AST_NEXT_FIRST: assert property (
    ev && !fail && mode_reg == rrp_pkg::MODE_NEXT && !ptr_set |=>
      ptr_reg[$past(file)] == 1 && ptr_set_reg[$past(file)])
    else $error("next without pointer did not go to record one");
  AST_LINEAR_END: assert property (
    ev && mode_reg == rrp_pkg::MODE_NEXT && at_last && !cyc |=>
      ptr_reg[$past(file)] == $past(ptr) && state_reg == rrp_pkg::ST_STATUS ##1
      !data_seen_reg)
    else $error("next at end of linear file moved pointer or sent data");
  AST_CYCLIC_WRAP: assert property (
    ev && !fail && mode_reg == rrp_pkg::MODE_NEXT && at_last && cyc |=>
      ptr_reg[$past(file)] == 1)
    else $error("cyclic next did not wrap to record one");
  AST_PREV_WRAP: assert property (
    ev && !fail && mode_reg == rrp_pkg::MODE_PREVIOUS && at_first && cyc |=>
      ptr_reg[$past(file)] == $past(nrec))
    else $error("cyclic previous did not wrap to last record");
  AST_FAIL_KEEP: assert property (
    ev && fail |=> ptr_reg[$past(file)] == $past(ptr) && !resp_valid_o ##1 !resp_valid_o)
    else $error("failed command changed pointer or sent data");
  AST_SELECT_CLEAR: assert property (
    sel_fire |=> !ptr_set_reg[$past(sel_file_i)])
    else $error("selection left a pointer established");
  AST_RESP_STALL: assert property (
    resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_data_o))
    else $error("response byte dropped under back-pressure");

  COV_READ_OK: cover property (sw_valid_o && data_seen_reg);
  COV_DENIED: cover property (sw_valid_o && sw2_o == 8'h82);
  COV_CYCLIC_WRAP: cover property (ev && !fail && at_last && cyc);
  COV_LINEAR_STOP: cover property (ev && at_first && !cyc &&
    mode_reg == rrp_pkg::MODE_PREVIOUS);
endmodule : rrp_read_record_engine

/* File: verification/rrp_mem_model.sv */
// Record store seen behind the engine's byte read port
`timescale 1ns/1ps

// ==========================================
// Behavioural record memory
module rrp_mem_model (
  input wire logic clk_sys_i,
  input wire logic mem_rd_i,
  input wire logic [1:0] mem_file_i,
  input wire logic [7:0] mem_rec_i,
  input wire logic [7:0] mem_byte_i,
  output logic [7:0] mem_rdata_o
);
  // Byte value encodes file, record and byte index so misaddressing shows
  wire logic [7:0] byte_value = {mem_file_i, mem_rec_i[1:0], mem_byte_i[3:0]};

  initial mem_rdata_o = 8'h5A;

  // Outside the valid cycle the data toggles, so a sample one cycle late never matches
  always @(posedge clk_sys_i) begin
    if (mem_rd_i) begin
      mem_rdata_o <= byte_value;
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule : rrp_mem_model

/* File: verification/tb_record_read_pointer_engine.sv */
// Self-checking bench for the read-record engine
`timescale 1ns/1ps

// ==========================================
// Bench top
module tb_record_read_pointer_engine;
  localparam logic [1:0] CUR = rrp_pkg::MODE_CURRENT;
  localparam logic [1:0] ABS = rrp_pkg::MODE_ABSOLUTE;
  localparam logic [1:0] NXT = rrp_pkg::MODE_NEXT;
  localparam logic [1:0] PRV = rrp_pkg::MODE_PREVIOUS;
  localparam logic [15:0] OK = {rrp_pkg::SW1_OK, rrp_pkg::SW2_OK};
  localparam logic [15:0] NF = {rrp_pkg::SW1_NOT_FOUND, rrp_pkg::SW2_REC_NOT_FOUND};
  localparam logic [15:0] SEC = {rrp_pkg::SW1_SECURITY, rrp_pkg::SW2_SECURITY};
  localparam logic [15:0] STR = {rrp_pkg::SW1_STRUCTURE, rrp_pkg::SW2_STRUCTURE};
  localparam logic [15:0] LEN = {rrp_pkg::SW1_WRONG_LEN, rrp_pkg::SW2_WRONG_LEN};

  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic sel_valid_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_sfi_valid_i = 1'b0;
  logic resp_ready_i = 1'b1;
  logic [1:0] sel_file_i = 2'h0;
  logic [1:0] cmd_mode_i = 2'h0;
  logic [7:0] cmd_rec_num_i = 8'h00;
  logic [7:0] cmd_len_i = 8'h00;
  logic [4:0] cmd_short_file_identifier_i = 5'h00;
  // File 0 linear, 1 cyclic with records longer than the FIFO, 2 not a record file
  logic [3:0] file_is_record_i = 4'hB;
  logic [3:0] file_cyclic_i = 4'h2;
  logic [3:0] read_access_ok_i = 4'h7;
  logic [31:0] file_num_rec_i = 32'h03030303;
  logic [31:0] file_rec_len_i = 32'h02020A02;
  logic sel_ready_o, cmd_ready_o, mem_rd_o, resp_valid_o, sw_valid_o;
  logic [1:0] mem_file_o, cur_file_o;
  logic [7:0] mem_rec_o, mem_byte_o, mem_rdata_i, resp_data_o, sw1_o, sw2_o;
  int n_mismatch = 0;
  int comparisons = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  rrp_read_record_engine #(.NUM_FILES(4), .REC_W(8), .LEN_W(8), .FIFO_DEPTH(8)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .sel_valid_i(sel_valid_i),
    .sel_file_i(sel_file_i), .sel_ready_o(sel_ready_o), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_mode_i(cmd_mode_i), .cmd_rec_num_i(cmd_rec_num_i),
    .cmd_len_i(cmd_len_i), .cmd_sfi_valid_i(cmd_sfi_valid_i),
    .cmd_short_file_identifier_i(cmd_short_file_identifier_i),
    .file_is_record_i(file_is_record_i), .file_cyclic_i(file_cyclic_i),
    .read_access_ok_i(read_access_ok_i), .file_num_rec_i(file_num_rec_i),
    .file_rec_len_i(file_rec_len_i), .mem_rd_o(mem_rd_o), .mem_file_o(mem_file_o),
    .mem_rec_o(mem_rec_o), .mem_byte_o(mem_byte_o), .mem_rdata_i(mem_rdata_i),
    .resp_valid_o(resp_valid_o), .resp_ready_i(resp_ready_i), .resp_data_o(resp_data_o),
    .sw_valid_o(sw_valid_o), .sw1_o(sw1_o), .sw2_o(sw2_o), .cur_file_o(cur_file_o));

  rrp_mem_model mem (
    .clk_sys_i(clk_sys_i), .mem_rd_i(mem_rd_o), .mem_file_i(mem_file_o),
    .mem_rec_i(mem_rec_o), .mem_byte_i(mem_byte_o), .mem_rdata_o(mem_rdata_i));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic sel(input logic [1:0] f);
    @(negedge clk_sys_i);
    sel_file_i = f;
    sel_valid_i = 1'b1;
    @(negedge clk_sys_i);
    sel_valid_i = 1'b0;
  endtask : sel

  // One command: f is the file whose bytes are expected, er the record, nb the byte count
  task automatic rd(input logic [1:0] m, input logic [7:0] r, input logic sv,
                    input logic [1:0] f, input logic [7:0] er, input int nb,
                    input logic [15:0] sw, input int stall);
    int n;
    int k;
    logic done;
    n = 0;
    done = 1'b0;
    @(negedge clk_sys_i);
    for (k = 0; k < 50 && cmd_ready_o !== 1'b1; k++) @(negedge clk_sys_i);
    if (k == 50) begin
      n_mismatch++;
      $display("mismatch cmd_ready expected 1 seen 0");
      final_report();
    end
    cmd_mode_i = m;
    cmd_rec_num_i = r;
    cmd_sfi_valid_i = sv;
    cmd_short_file_identifier_i = {3'h0, f};
    cmd_valid_i = 1'b1;
    resp_ready_i = (stall == 0);
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
    for (k = 0; k < 300 && !done; k++) begin
      resp_ready_i = (k >= stall);
      if (resp_valid_o === 1'b1 && resp_ready_i) begin
        chk("resp_data", {f, er[1:0], n[3:0]}, resp_data_o);
        n++;
      end
      if (sw_valid_o === 1'b1) begin
        chk("sw1", sw[15:8], sw1_o);
        chk("sw2", sw[7:0], sw2_o);
        chk("byte_count", nb[7:0], n[7:0]);
        done = 1'b1;
      end
      if (!done) @(negedge clk_sys_i);
    end
    if (!done) begin
      n_mismatch++;
      $display("mismatch sw_valid expected 1 seen 0");
      final_report();
    end
  endtask : rd

  // ==========================================
  // Scenarios
  task automatic t_access();
    sel(2'h3);
    rd(ABS, 8'h01, 1'b0, 2'h3, 8'h00, 0, SEC, 0);
    read_access_ok_i = 4'hF;
    rd(ABS, 8'h01, 1'b0, 2'h3, 8'h01, 2, OK, 0);
    sel(2'h2);
    rd(CUR, 8'h00, 1'b0, 2'h2, 8'h00, 0, STR, 0);
  endtask : t_access

  task automatic t_linear();
    sel(2'h0);
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h01, 2, OK, 0);
    rd(ABS, 8'h02, 1'b0, 2'h0, 8'h02, 2, OK, 0);
    rd(CUR, 8'h00, 1'b0, 2'h0, 8'h01, 2, OK, 0);
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h02, 2, OK, 0);
    rd(ABS, 8'h04, 1'b0, 2'h0, 8'h00, 0, NF, 0);
    cmd_len_i = 8'h03;
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h00, 0, LEN, 0);
    cmd_len_i = 8'h02;
    rd(CUR, 8'h00, 1'b0, 2'h0, 8'h02, 2, OK, 0);
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h03, 2, OK, 0);
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h00, 0, NF, 0);
    rd(PRV, 8'h00, 1'b0, 2'h0, 8'h02, 2, OK, 0);
    sel(2'h0);
    rd(PRV, 8'h00, 1'b0, 2'h0, 8'h03, 2, OK, 0);
    sel(2'h0);
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h01, 2, OK, 0);
    rd(PRV, 8'h00, 1'b0, 2'h0, 8'h00, 0, NF, 0);
    rd(CUR, 8'h00, 1'b0, 2'h0, 8'h01, 2, OK, 0);
    cmd_len_i = 8'h00;
  endtask : t_linear

  // Record of ten bytes with the consumer stalled fills the eight-word FIFO
  task automatic t_cyclic();
    sel(2'h1);
    cmd_len_i = 8'h0A;
    rd(PRV, 8'h00, 1'b0, 2'h1, 8'h03, 10, OK, 30);
    rd(NXT, 8'h00, 1'b0, 2'h1, 8'h01, 10, OK, 0);
    rd(PRV, 8'h00, 1'b0, 2'h1, 8'h03, 10, OK, 0);
    cmd_len_i = 8'h00;
  endtask : t_cyclic

  task automatic t_sfi();
    sel(2'h2);
    rd(ABS, 8'h01, 1'b1, 2'h0, 8'h01, 2, OK, 0);
    chk("cur_file", 8'h00, {6'h00, cur_file_o});
    rd(CUR, 8'h00, 1'b0, 2'h0, 8'h00, 0, NF, 0);
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h01, 2, OK, 0);
  endtask : t_sfi

  task automatic t_reset();
    sel(2'h0);
    rd(NXT, 8'h00, 1'b0, 2'h0, 8'h01, 2, OK, 0);
    sel(2'h1);
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("cur_file", 8'h00, {6'h00, cur_file_o});
    rd(CUR, 8'h00, 1'b0, 2'h0, 8'h00, 0, NF, 0);
  endtask : t_reset

  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_access();
    t_linear();
    t_cyclic();
    t_sfi();
    t_reset();
    final_report();
  end
endmodule : tb_record_read_pointer_engine
